//--- acp_pkg.sv
// Purpose: shared constants and types of the channel power / feature bank
// Assumes: 8-bit program registers reached over the serial port
// Notes:   one place for every offset, field position and reset value
`default_nettype none

package acp_pkg;

   // variant width: 8 channels, 4 for the smaller part
   localparam int NUM_CHAN_DEF = 8;
   localparam int REG_BITS     = 8;

   // register offsets on the serial port
   localparam logic [6:0] ADDR_CHAN_PD = 7'h02;
   localparam logic [6:0] ADDR_FEATURE = 7'h03;

   // reset values
   localparam logic [7:0] CHAN_PD_RST  = 8'h00;
   localparam logic [1:0] DEV_ID_RST   = 2'h0;
   localparam logic       ALARM_EN_RST = 1'b0;
   localparam logic [2:0] FMT_RST      = 3'h0;

   // feature register field positions
   localparam int FEAT_DEV_LSB   = 6;
   localparam int FEAT_RSV_HI    = 5;
   localparam int FEAT_ALARM_BIT = 4;
   localparam int FEAT_RSV_LO    = 3;
   localparam int FEAT_FMT_LSB   = 0;

   // command word layout: address, write flag, data
   localparam int CMD_BITS     = 16;
   localparam int CMD_ADDR_LSB = 9;
   localparam int CMD_WR_BIT   = 8;

   // output word: 25 bits, first one out at the 16th falling edge
   localparam int         WORD_BITS     = 25;
   localparam logic [5:0] LOAD_FALL_IDX = 6'h0F;
   localparam logic [5:0] FALL_CNT_MAX  = 6'h3F;
   localparam int         RESULT_BITS   = 12;
   localparam int         OW_RESULT_LSB = 13;
   localparam int         OW_CHAN_LSB   = 5;
   localparam int         OW_DEV_LSB    = 3;
   localparam int         OW_SPAN_LSB   = 0;
   localparam int         SPAN_BITS     = 4;

   // output word format codes
   localparam logic [2:0] FMT_RESULT = 3'h0;
   localparam logic [2:0] FMT_CHAN   = 3'h1;
   localparam logic [2:0] FMT_DEV    = 3'h2;
   localparam logic [2:0] FMT_SPAN   = 3'h3;

   typedef struct packed {
      logic [1:0] dev_id;
      logic       alarm_en;
      logic [2:0] fmt;
   } acp_feature_type;

endpackage

`default_nettype wire

//--- acp_link_if.sv
// Purpose: carries serial-port events from the front end to the bank
// Assumes: one clock domain, driven by acp_spi_front
// Notes:   no clocking block; plain signals with two modports
`default_nettype none

interface acp_link_if;
   logic       frame_active;
   logic       sclk_rise;
   logic       sclk_fall;
   logic [5:0] fall_idx;
   logic [15:0] cmd_word;

   modport front (
      output frame_active,
      output sclk_rise,
      output sclk_fall,
      output fall_idx,
      output cmd_word
   );

   modport core (
      input frame_active,
      input sclk_rise,
      input sclk_fall,
      input fall_idx,
      input cmd_word
   );
endinterface

`default_nettype wire

//--- acp_spi_front.sv
// Purpose: synchronise serial pins, find clock edges, collect the command
// Assumes: serial clock well below a quarter of clock_i
// Notes:   falling edges counted before the current one appear as fall_idx
`default_nettype none

module acp_spi_front
   import acp_pkg::*;
(
   input  wire logic    clock_i,
   input  wire logic    srst_i,
   input  wire logic    sclk_i,
   input  wire logic    cs_n_i,
   input  wire logic    sdi_i,
   acp_link_if.front    link
);
   import acp_pkg::*;

   typedef struct packed {
      logic        sclk_s1;
      logic        sclk_s2;
      logic        sclk_d;
      logic        cs_s1;
      logic        cs_s2;
      logic        sdi_s1;
      logic        sdi_s2;
      logic [5:0]  fall_cnt;
      logic [15:0] shift;
   } acp_front_type;

   // select idles high, so the frame looks closed out of reset
   localparam acp_front_type FRONT_RST = '{
      sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_d: 1'b0,
      cs_s1: 1'b1, cs_s2: 1'b1, sdi_s1: 1'b0, sdi_s2: 1'b0,
      fall_cnt: 6'h00, shift: 16'h0000};

   acp_front_type st;
   acp_front_type next_st;
   logic          active;
   logic          rise;
   logic          fall;

   // edges seen only on second stage vs its delayed copy
   always_comb begin
      active  = ~st.cs_s2;
      rise    = active & st.sclk_s2 & ~st.sclk_d;
      fall    = active & ~st.sclk_s2 & st.sclk_d;
      next_st = st;
      next_st.sclk_s1 = sclk_i;
      next_st.sclk_s2 = st.sclk_s1;
      next_st.sclk_d  = st.sclk_s2;
      next_st.cs_s1   = cs_n_i;
      next_st.cs_s2   = st.cs_s1;
      next_st.sdi_s1  = sdi_i;
      next_st.sdi_s2  = st.sdi_s1;
      if (!active) begin
         next_st.fall_cnt = 6'h00;
      end else begin
         if (rise) begin
            next_st.shift = {st.shift[CMD_BITS-2:0], st.sdi_s2};
         end
         // saturate so long frames never wrap back onto the load edge
         if (fall && st.fall_cnt != FALL_CNT_MAX) begin
            next_st.fall_cnt = st.fall_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st <= FRONT_RST;
      end else begin
         st <= next_st;
      end
   end

   // event outputs to the bank
   assign link.frame_active = active;
   assign link.sclk_rise    = rise;
   assign link.sclk_fall    = fall;
   assign link.fall_idx     = st.fall_cnt;
   assign link.cmd_word     = st.shift;

endmodule // acp_spi_front

`default_nettype wire

//--- acp_cfg_top.sv
// Purpose: channel power-down and feature registers plus output word shifter
// Assumes: conversion result, channel and span fields come from clock_i logic
// Notes:   registers written and read by 16-bit serial commands
//          command: [15:9] address, [8] write flag, [7:0] data, msb first
//          reads of 02h/03h put the byte in word bits 24:17, rest low
//          other reads return the conversion word of the current format
//
// Notes on behaviour
// R1 - one power-down bit per channel, reset 0; set means off, not scanned
// R2 - four-channel part ignores writes to absent channel bits
// R3 - four-channel part reads absent channel bits as ones
// R4 - feature bits 7:6 hold daisy-chain id, reset 0, positions 0 to 3
// R5 - feature bit 4 enables alarms, reset 0
// R6 - host writes zero to feature bits 5 and 3, read-only zero
// R7 - feature bits 2:0 select output word format, reset 0
// R8 - output stream starts at 16th falling serial edge, no latency
// R9 - word bits 24:9 carry 12-bit result msb first then four zeros
// R10 - format 0 result, 1 adds channel, 2 adds device, 3 adds span
// R11 - word bits 8:5 carry four-bit channel address when enabled
// R12 - word bits 4:3 carry daisy-chain device address when enabled
// R13 - word bits 2:0 carry three low span bits of selected channel
// R14 - all channels off means front ends off and output invalid
// R15 - host should not power down the manually selected channel
// R16 - reported span bits come from the per-channel four-bit span field
// R17 - reserved feature bits read zero whatever was written
// R18 - format codes 4 to 7 behave as format 0
`default_nettype none

module acp_cfg_top
   import acp_pkg::*;
#(
   parameter int NUM_CHAN = NUM_CHAN_DEF
) (
   input  wire logic                      clock_i,
   input  wire logic                      srst_i,
   input  wire logic                      sclk_i,
   input  wire logic                      cs_n_i,
   input  wire logic                      sdi_i,
   input  wire logic [RESULT_BITS-1:0]    conv_result_i,
   input  wire logic [3:0]                conv_chan_i,
   input  wire logic [NUM_CHAN*4-1:0]     chan_input_span_i,
   output logic                           serial_data_out_o,
   output logic [NUM_CHAN-1:0]            chan_afe_off_o,
   output logic [NUM_CHAN-1:0]            scan_allowed_o,
   output logic                           all_afe_off_o,
   output logic                           alarm_enable_o,
   output logic [1:0]                     daisy_dev_id_o,
   output logic [2:0]                     output_word_format_o
);
   import acp_pkg::*;

   typedef struct packed {
      logic [7:0]           pd;
      acp_feature_type      feat;
      logic [WORD_BITS-1:0] out_sr;
      logic                 serial_data_out;
   } acp_core_type;

   // every register and the shifter clear to zero on reset
   localparam acp_core_type CORE_RST = '{
      pd: CHAN_PD_RST,
      feat: '{dev_id: DEV_ID_RST, alarm_en: ALARM_EN_RST, fmt: FMT_RST},
      out_sr: '0,
      serial_data_out: 1'b0};

   // front-end events, all already on clock_i
   acp_link_if link ();

   acp_core_type         st;
   acp_core_type         next_st;
   logic [7:0]           exist_mask;
   logic [7:0]           pd_read;
   logic [7:0]           feat_read;
   logic [6:0]           cmd_addr;
   logic                 cmd_wr;
   logic [7:0]           cmd_data;
   logic [SPAN_BITS-1:0] span_sel;
   logic [WORD_BITS-1:0] conv_word;
   logic [WORD_BITS-1:0] load_word;
   logic                 rd_pd;
   logic                 rd_feat;
   logic                 wr_pd;
   logic                 wr_feat;

   acp_spi_front u_front (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .sclk_i  (sclk_i),
      .cs_n_i  (cs_n_i),
      .sdi_i   (sdi_i),
      .link    (link)
   );

   // which of the eight register bits belong to a real channel
   // absent channels get no port bits; their register bits stay zero
   for (genvar i = 0; i < 8; i++) begin : g_chan
      assign exist_mask[i] = (i < NUM_CHAN);
      if (i < NUM_CHAN) begin : g_real
         assign chan_afe_off_o[i] = st.pd[i];   // see R1
         assign scan_allowed_o[i] = ~st.pd[i];  // see R1
      end
   end

   // register read views
   // absent channel bits read as ones, reserved feature bits as zero
   always_comb begin
      pd_read   = st.pd | ~exist_mask;          // see R3
      feat_read = 8'h00;                        // see R17
      feat_read[FEAT_DEV_LSB +: 2] = st.feat.dev_id;
      feat_read[FEAT_ALARM_BIT]    = st.feat.alarm_en;
      feat_read[FEAT_FMT_LSB +: 3] = st.feat.fmt;
   end

   // command fields, valid once sixteen bits are in
   assign cmd_addr = link.cmd_word[CMD_BITS-1:CMD_ADDR_LSB];
   assign cmd_wr   = link.cmd_word[CMD_WR_BIT];
   assign cmd_data = link.cmd_word[REG_BITS-1:0];

   // command decode, looked at only on the load edge; a frame cut
   // before its 16th fall never reaches that edge and changes nothing
   assign rd_pd   = !cmd_wr && cmd_addr == ADDR_CHAN_PD;
   assign rd_feat = !cmd_wr && cmd_addr == ADDR_FEATURE;
   assign wr_pd   = cmd_wr && cmd_addr == ADDR_CHAN_PD;
   assign wr_feat = cmd_wr && cmd_addr == ADDR_FEATURE;

   // span of the converted channel; out-of-range channel reads zero
   // a four-channel part has no span field for channels 4 to 7
   always_comb begin
      span_sel = '0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (conv_chan_i == 4'(i)) begin
            span_sel = chan_input_span_i[i*SPAN_BITS +: SPAN_BITS]; // see R16
         end
      end
   end

   // output word build; unused trailing bits stay low
   always_comb begin
      conv_word = '0;
      conv_word[OW_RESULT_LSB +: RESULT_BITS] = conv_result_i; // see R9
      case (st.feat.fmt)                                      // see R10
         FMT_CHAN: begin
            conv_word[OW_CHAN_LSB +: 4] = conv_chan_i;        // see R11
         end
         FMT_DEV: begin
            conv_word[OW_CHAN_LSB +: 4] = conv_chan_i;
            conv_word[OW_DEV_LSB +: 2]  = st.feat.dev_id;     // see R12
         end
         FMT_SPAN: begin
            conv_word[OW_CHAN_LSB +: 4] = conv_chan_i;
            conv_word[OW_DEV_LSB +: 2]  = st.feat.dev_id;
            conv_word[OW_SPAN_LSB +: 3] = span_sel[2:0];      // see R13
         end
         default: begin
            conv_word[OW_RESULT_LSB-1:0] = '0;                // see R18
         end
      endcase
   end

   // a read of our own registers replaces the conversion word;
   // the byte leaves msb first from the load edge, zeros after it
   always_comb begin
      load_word = conv_word;
      if (rd_pd) begin
         load_word = {pd_read, {(WORD_BITS-REG_BITS){1'b0}}};
      end else if (rd_feat) begin
         load_word = {feat_read, {(WORD_BITS-REG_BITS){1'b0}}};
      end
   end

   // register writes and the output shifter, both on falling edges;
   // a write and the word it launches share one edge, so the new
   // format shows from the next frame on
   always_comb begin
      next_st = st;
      // deselect clears the shifter so each frame starts from zero
      if (!link.frame_active) begin
         next_st.serial_data_out    = 1'b0;
         next_st.out_sr = '0;
      end else if (link.sclk_fall) begin
         if (link.fall_idx == LOAD_FALL_IDX) begin           // see R8
            // word built from settings in force before this command
            next_st.serial_data_out    = load_word[WORD_BITS-1];
            next_st.out_sr = {load_word[WORD_BITS-2:0], 1'b0};
            // absent channel bits never store a one
            if (wr_pd) begin
               next_st.pd = cmd_data & exist_mask;           // see R2
            end
            if (wr_feat) begin
               next_st.feat.dev_id   = cmd_data[FEAT_DEV_LSB +: 2]; // see R4
               next_st.feat.alarm_en = cmd_data[FEAT_ALARM_BIT];    // see R5
               next_st.feat.fmt      = cmd_data[FEAT_FMT_LSB +: 3]; // see R7
               // bits 5 and 3 are dropped, see R6
            end
         end else if (link.fall_idx > LOAD_FALL_IDX) begin
            next_st.serial_data_out    = st.out_sr[WORD_BITS-1];
            next_st.out_sr = {st.out_sr[WORD_BITS-2:0], 1'b0};
         end
      end
   end

   // one register stage for all core state, synchronous reset
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st <= CORE_RST;                                     // see R1
      end else begin
         st <= next_st;
      end
   end

   // status outputs; a powered-down manual channel is the host's hazard
   // absent channels count as off, so a four-channel part flags invalid
   // output once its four real bits are all set
   assign all_afe_off_o        = &pd_read;                   // see R14
   assign serial_data_out_o    = st.serial_data_out;
   assign alarm_enable_o       = st.feat.alarm_en;
   assign daisy_dev_id_o       = st.feat.dev_id;
   assign output_word_format_o = st.feat.fmt;

endmodule // acp_cfg_top

`default_nettype wire

//--- acp_cfg_chk.sv
// Purpose: port-level assertions for the config bank
// Assumes: serial clock halves of five clock_i cycles or more
// Notes:   bound to every acp_cfg_top instance
`default_nettype none

module acp_cfg_chk
   import acp_pkg::*;
#(
   parameter int NUM_CHAN = NUM_CHAN_DEF
) (
   input wire logic                   clock_i,
   input wire logic                   srst_i,
   input wire logic                   sclk_i,
   input wire logic                   cs_n_i,
   input wire logic                   sdi_i,
   input wire logic [RESULT_BITS-1:0] conv_result_i,
   input wire logic [3:0]             conv_chan_i,
   input wire logic [NUM_CHAN*4-1:0]  chan_input_span_i,
   input wire logic                   serial_data_out_o,
   input wire logic [NUM_CHAN-1:0]    chan_afe_off_o,
   input wire logic [NUM_CHAN-1:0]    scan_allowed_o,
   input wire logic                   all_afe_off_o,
   input wire logic                   alarm_enable_o,
   input wire logic [1:0]             daisy_dev_id_o,
   input wire logic [2:0]             output_word_format_o
);
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   // power and scan views of one register, then reset values of both registers
   scan_inv_a: assert property (
      scan_allowed_o == ~chan_afe_off_o) else $error("scan mask wrong");
   all_off_a: assert property (
      all_afe_off_o == &chan_afe_off_o) else $error("all-off flag wrong");
   reset_val_a: assert property ($fell(srst_i) |->
      chan_afe_off_o == '0 && alarm_enable_o == ALARM_EN_RST &&
      daisy_dev_id_o == DEV_ID_RST && output_word_format_o == FMT_RST)
      else $error("register not at reset value");
   // writes land only just after a falling serial edge in a frame
   pd_quiet_a: assert property ($changed(chan_afe_off_o) |->
      !cs_n_i && !sclk_i) else $error("power-down changed off frame");
   feat_quiet_a: assert property ($changed({daisy_dev_id_o,
      alarm_enable_o, output_word_format_o}) |-> !cs_n_i && !sclk_i)
      else $error("feature changed off frame");
   // output quiet between frames, steady while the host samples
   sdo_idle_a: assert property (cs_n_i[*6] |->
      !serial_data_out_o) else $error("output busy outside frame");
   sdo_hold_a: assert property ((sclk_i && !cs_n_i)[*5] |->
      $stable(serial_data_out_o)) else $error("output moved while high");
   sdo_launch_a: assert property (!cs_n_i &&
      $changed(serial_data_out_o) |-> !sclk_i)
      else $error("output launched on wrong edge");

   cov_all_off: cover property ($rose(all_afe_off_o));
   cov_fmt: cover property (output_word_format_o == FMT_SPAN);
   cov_sdo: cover property ($rose(serial_data_out_o));
endmodule // acp_cfg_chk

bind acp_cfg_top acp_cfg_chk #(.NUM_CHAN(NUM_CHAN)) acp_cfg_chk_i (
   .clock_i(clock_i), .srst_i(srst_i), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .sdi_i(sdi_i), .conv_result_i(conv_result_i),
   .conv_chan_i(conv_chan_i), .chan_input_span_i(chan_input_span_i),
   .serial_data_out_o(serial_data_out_o),
   .chan_afe_off_o(chan_afe_off_o), .scan_allowed_o(scan_allowed_o),
   .all_afe_off_o(all_afe_off_o), .alarm_enable_o(alarm_enable_o),
   .daisy_dev_id_o(daisy_dev_id_o),
   .output_word_format_o(output_word_format_o));

`default_nettype wire

//--- acp_host_model.sv
// Purpose: behavioural host clocking commands in and words out
// Assumes: serial clock idle low, 125 ns period
// Notes:   samples both device outputs at each rising edge
`default_nettype none

module acp_host_model
   import acp_pkg::*;
(
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      sdi_o,
   input  wire logic sdo_a_i,
   input  wire logic sdo_b_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle bus: clock still, frame deselected
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   // one 41-cycle frame; reserved feature bits cleared unless asked
   task automatic xfer(input logic [15:0] cmd, input logic keep_rsv,
                       output logic [24:0] wa, output logic [24:0] wb);
      if (!keep_rsv && cmd[15:8] == {ADDR_FEATURE, 1'b1}) begin
         cmd[5] = 1'b0;
         cmd[3] = 1'b0;
      end
      // called on a falling clock edge; the 1 ns step keeps every pin
      // move of the frame clear of both clock edges
      #1;
      cs_n_o = 1'b0;
      for (int i = 0; i < 41; i++) begin
         // tail bits toggle so nothing leans on a stale level
         sdi_o = (i < 16) ? cmd[15-i] : ~sdi_o;
         #62.5;
         wa = {wa[23:0], sdo_a_i};
         wb = {wb[23:0], sdo_b_i};
         sclk_o = 1'b1;
         #62.5;
         sclk_o = 1'b0;
      end
      #62.5;
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      // frame plus gap is whole clock periods: next call on a falling edge
      #101.5;
   endtask
endmodule // acp_host_model

`default_nettype wire

//--- test_acp_cfg_top.sv
// Purpose: self-checking bench for the channel power / feature bank
// Assumes: an eight- and a four-channel bank share one host
// Notes:   each scenario is a task; words compared whole
`default_nettype none

module test_acp_cfg_top;
   timeunit 1ns;
   timeprecision 100ps;
   import acp_pkg::*;

   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        sclk, cs_n, sdi, sdo_a, sdo_b;
   logic [11:0] result = 12'hA5C;
   logic [3:0]  chan = 4'h5;
   logic [31:0] span = 32'hFEDCBA98;
   logic [7:0]  off_a, scan_a;
   logic [3:0]  off_b;
   logic        all_a, all_b, alarm;
   logic [1:0]  dev;
   logic [2:0]  fmt;
   logic [24:0] wa, wb;
   int          bad_count = 0;
   int          total_checks = 0;

   always #5 clock_i = ~clock_i;

   acp_host_model acp_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n),
      .sdi_o(sdi), .sdo_a_i(sdo_a), .sdo_b_i(sdo_b));
   acp_cfg_top acp_cfg_top_i (.clock_i(clock_i), .srst_i(srst_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .conv_result_i(result),
      .conv_chan_i(chan), .chan_input_span_i(span),
      .serial_data_out_o(sdo_a), .chan_afe_off_o(off_a),
      .scan_allowed_o(scan_a), .all_afe_off_o(all_a),
      .alarm_enable_o(alarm), .daisy_dev_id_o(dev),
      .output_word_format_o(fmt));
   // four-channel part on the same frames, its own output line
   acp_cfg_top #(.NUM_CHAN(4)) acp_cfg_top_4_i (.clock_i(clock_i),
      .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
      .conv_result_i(result), .conv_chan_i(chan),
      .chan_input_span_i(span[15:0]), .serial_data_out_o(sdo_b),
      .chan_afe_off_o(off_b), .scan_allowed_o(), .all_afe_off_o(all_b),
      .alarm_enable_o(), .daisy_dev_id_o(), .output_word_format_o());

   task automatic chk_word(input logic [24:0] got, input logic [24:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected word at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected port at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d,
                     input logic k);
      acp_host_model_i.xfer({a, 1'b1, d}, k, wa, wb);
   endtask

   task automatic rd(input logic [6:0] a);
      acp_host_model_i.xfer({a, 1'b0, 8'h00}, 1'b0, wa, wb);
   endtask

   task automatic t_reset;
      chk_port({1'b0, off_a, alarm, dev, fmt, all_a}, 16'h0000);
      rd(ADDR_CHAN_PD);
      chk_word(wa, 25'h0000000);
      rd(ADDR_FEATURE);
      chk_word(wa, 25'h0000000);
      $display("test reset done");
   endtask

   task automatic t_power;
      wr(ADDR_CHAN_PD, 8'h5A, 1'b0);
      chk_port({off_a, scan_a}, 16'h5AA5);
      chk_port({12'h000, off_b}, 16'h000A);
      rd(ADDR_CHAN_PD);
      chk_word(wa, {8'h5A, 17'h00000});
      chk_word(wb, {8'hFA, 17'h00000});
      wr(ADDR_CHAN_PD, 8'h0F, 1'b0);
      chk_port({14'h0000, all_a, all_b}, 16'h0001);
      wr(ADDR_CHAN_PD, 8'hFF, 1'b0);
      chk_port({14'h0000, all_a, all_b}, 16'h0003);
      wr(ADDR_CHAN_PD, 8'h00, 1'b0);
      $display("test power done");
   endtask

   task automatic t_feature;
      wr(ADDR_FEATURE, 8'hFF, 1'b1);
      chk_port({10'h000, dev, alarm, fmt}, 16'h003F);
      rd(ADDR_FEATURE);
      chk_word(wa, {8'hD7, 17'h00000});
      wr(7'h04, 8'h00, 1'b0);
      rd(ADDR_FEATURE);
      chk_word(wa, {8'hD7, 17'h00000});
      wr(ADDR_FEATURE, 8'h00, 1'b0);
      chk_port({10'h000, dev, alarm, fmt}, 16'h0000);
      $display("test feature done");
   endtask

   // every format code, daisy id 2, channel 5 result
   task automatic t_format;
      logic [24:0] exp;
      for (int f = 0; f < 8; f++) begin
         wr(ADDR_FEATURE, {5'h10, f[2:0]}, 1'b0);
         rd(7'h00);
         exp = {result, 13'h0000};
         if (f >= 1 && f <= 3) exp[8:5] = chan;
         if (f == 2 || f == 3) exp[4:3] = 2'h2;
         if (f == 3) exp[2:0] = span[22:20];
         chk_word(wa, exp);
      end
      $display("test format done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence, inputs moved on the falling clock edge
   initial begin
      repeat (6) @(negedge clock_i);
      srst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      t_reset;
      t_power;
      t_feature;
      t_format;
      final_report;
   end

   // about 30 frames of 5.3 us each fit well inside this
   initial begin
      #400us;
      bad_count++;
      final_report;
   end
endmodule // test_acp_cfg_top

`default_nettype wire
